//--- tpw_regs.svh
// Register offsets, reset values and timing constants of the timer block
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH

// ----------------------------------------------------------------
// Address width and register offsets on the plain register port
// ----------------------------------------------------------------
`define TPW_ADDR_W 8
`define TPW_OFF_COUNT 8'h09
`define TPW_OFF_CTRL1 8'h0A
`define TPW_OFF_CTRL2 8'h0B
`define TPW_OFF_DUTY 8'h0C
`define TPW_OFF_STATUS 8'h20
`define TPW_OFF_MASK 8'h21

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPW_CTRL1_RST 8'h00
`define TPW_CTRL2_RST 8'h3F
`define TPW_DUTY_RST 8'h00
`define TPW_COUNT_RST 10'h000
`define TPW_STATUS_RST 8'h00
`define TPW_MASK_RST 8'h00
`define TPW_READ_ZERO 8'h00

// ----------------------------------------------------------------
// Counter constants, shared high-bit positions and the status bit position
// ----------------------------------------------------------------
`define TPW_FULL_RELOAD 10'h3FF
`define TPW_ZERO_COUNT 10'h000
`define TPW_ONE_COUNT 10'h001
`define TPW_SHB_RL_HI 7
`define TPW_SHB_RL_LO 6
`define TPW_SHB_DUTY_HI 3
`define TPW_SHB_DUTY_LO 2
`define TPW_ST_UNDERFLOW 0

`endif

//--- tpw_pkg.sv
// Types used by the timer block; its prescaler imports them but uses none
package tpw_pkg;

  // ----------------------------------------------------------------
  // Register layouts, port request and run state
  // ----------------------------------------------------------------
  // First control register
  typedef struct packed {
    logic pwm_pin_enable;
    logic pwm_polarity;
    logic [2:0] unused;
    logic one_shot_select;
    logic reload_select;
    logic timer_enable;
  } tpw_ctrl1_t;

  // Second control register
  typedef struct packed {
    logic [1:0] unused;
    logic clock_source_select;
    logic clock_edge_select;
    logic prescaler_disable_n;
    logic [2:0] prescaler_division_select;
  } tpw_ctrl2_t;

  // One register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tpw_bus_req_t;

  // Counter run state
  typedef enum logic [1:0] {
    TPW_IDLE = 2'b00,
    TPW_RUN = 2'b01,
    TPW_DONE = 2'b10
  } tpw_state_t;

endpackage : tpw_pkg

//--- tpw_prescaler.sv
// Power-of-two prescaler in front of the down-counter
`timescale 1ns/100ps
module tpw_prescaler #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic tick_in,
  input wire logic bypass,
  input wire logic [2:0] sel,
  input wire logic clear,
  output logic tick_out
);
  import tpw_pkg::*;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [W-1:0] cnt_r; // Free prescaler count

  // Low sel+1 bits set: 2 ** (sel + 1) input ticks per output tick
  function automatic logic [W-1:0] div_mask(input logic [2:0] s);
    div_mask = W'((2 << s) - 1);
  endfunction : div_mask

  // Count input ticks; a bypassed prescaler sits at zero
  always_ff @(posedge clock) begin
    if (reset || bypass || clear) begin
      cnt_r <= '0;
    end else if (tick_in) begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  // Pass through when bypassed, else fire on the last tick of a span
  always_comb begin
    if (bypass) begin
      tick_out = tick_in;
    end else begin
      tick_out = tick_in && ((cnt_r & div_mask(sel)) == div_mask(sel));
    end
  end

endmodule : tpw_prescaler

//--- tpw_timer.sv
// 10-bit down-counting timer with prescaler, PWM and register port
`timescale 1ns/100ps
`include "tpw_regs.svh"
module tpw_timer #(
  parameter int PRESCALE_W = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] shared_high_bits,
  input wire logic external_count_clock_pin,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  output logic pwm_output_pin_out,
  output logic pwm_output_pin_oe,
  output logic underflow_event,
  output logic irq
);
  import tpw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tpw_bus_req_t req; // Bundled port request
  tpw_ctrl1_t ctrl1_r; // First control register
  tpw_ctrl2_t ctrl2_r; // Second control register
  logic [7:0] duty_low_r; // Write-only duty low byte
  logic [7:0] status_r; // Sticky event bits
  logic [7:0] mask_r; // Interrupt mask
  logic [9:0] count_r; // Live down-counter
  logic [9:0] reload_r; // Stored reload value
  logic [9:0] count_nxt; // Next counter value
  tpw_state_t state_r; // Run state
  tpw_state_t state_nxt; // Next run state
  logic [7:0] reg_rdata_r; // Read data register
  logic irq_r; // Interrupt output register
  logic uf_r; // Underflow pulse register
  logic pin_out_r; // Pin level register
  logic pin_oe_r; // Pin enable register
  logic ext_s1_r; // Pin synchroniser, first stage
  logic ext_s2_r; // Pin synchroniser, second stage
  logic ext_s3_r; // Delayed copy for edge detection
  logic ext_edge; // Selected edge seen on the pin
  logic src_tick; // Tick before the prescaler
  logic cnt_tick; // Tick after the prescaler
  logic underflow; // Counter passes below zero
  logic wr_count; // Write to count register
  logic wr_ctrl2; // Write to second control register
  logic rd_status; // Read of status register
  logic [9:0] duty_full; // Ten-bit duty value
  logic pwm_active; // Waveform in its active phase
  logic pwm_level; // Waveform after polarity

  // Address match used by every write decoder and the status-read strobe below
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ----------------------------------------------------------------
  // Register writes and the status-read strobe
  // ----------------------------------------------------------------
  assign wr_count = req.wr && hit(req.addr, `TPW_OFF_COUNT);
  assign wr_ctrl2 = req.wr && hit(req.addr, `TPW_OFF_CTRL2);
  assign rd_status = req.rd && hit(req.addr, `TPW_OFF_STATUS);

  // First control register; reserved bits stay zero
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl1_r <= tpw_ctrl1_t'(`TPW_CTRL1_RST);
    end else if (req.wr && hit(req.addr, `TPW_OFF_CTRL1)) begin
      ctrl1_r <= tpw_ctrl1_t'(req.wdata);
      ctrl1_r.unused <= '0;
    end
  end

  // Second control register; top two bits stay zero
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl2_r <= tpw_ctrl2_t'(`TPW_CTRL2_RST);
    end else if (wr_ctrl2) begin
      ctrl2_r <= tpw_ctrl2_t'(req.wdata);
      ctrl2_r.unused <= '0;
    end
  end

  // Duty low byte; it cannot be read back
  always_ff @(posedge clock) begin
    if (reset) begin
      duty_low_r <= `TPW_DUTY_RST;
    end else if (req.wr && hit(req.addr, `TPW_OFF_DUTY)) begin
      duty_low_r <= req.wdata;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock) begin
    if (reset) begin
      mask_r <= `TPW_MASK_RST;
    end else if (req.wr && hit(req.addr, `TPW_OFF_MASK)) begin
      mask_r <= req.wdata;
    end
  end

  // Reload value: high bits from the shared register, low from the write
  always_ff @(posedge clock) begin
    if (reset) begin
      reload_r <= `TPW_COUNT_RST;
    end else if (wr_count) begin
      reload_r <= {shared_high_bits[`TPW_SHB_RL_HI:`TPW_SHB_RL_LO], req.wdata};
    end
  end

  // ----------------------------------------------------------------
  // Count source selection
  // ----------------------------------------------------------------
  // The pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= external_count_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Edge select one counts high-to-low, zero counts low-to-high
  always_comb begin
    if (ctrl2_r.clock_edge_select) begin
      ext_edge = ext_s3_r && !ext_s2_r;
    end else begin
      ext_edge = !ext_s3_r && ext_s2_r;
    end
  end

  // Instruction clock is every cycle of the block clock; a disabled
  // timer sees no ticks at all, so edges are simply dropped
  always_comb begin
    if (!ctrl1_r.timer_enable) begin
      src_tick = 1'b0;
    end else if (ctrl2_r.clock_source_select) begin
      src_tick = ext_edge;
    end else begin
      src_tick = 1'b1;
    end
  end

  // Prescaler cleared on each control-two write, so a live rate change
  // restarts from a fresh span at the new rate and causes no stray tick
  tpw_prescaler #(
    .W(PRESCALE_W)
  ) tpw_prescaler_i (
    .clock(clock),
    .reset(reset),
    .tick_in(src_tick),
    .bypass(ctrl2_r.prescaler_disable_n),
    .sel(ctrl2_r.prescaler_division_select),
    .clear(wr_ctrl2),
    .tick_out(cnt_tick)
  );

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------
  assign underflow = cnt_tick && (state_r == TPW_RUN) && (count_r == `TPW_ZERO_COUNT);

  // Next counter value and run state
  always_comb begin
    count_nxt = count_r;
    state_nxt = state_r;
    case (state_r)
      // Waiting for the first enable
      TPW_IDLE: begin
        if (ctrl1_r.timer_enable) begin
          state_nxt = TPW_RUN;
        end
      end
      // Counting
      TPW_RUN: begin
        if (cnt_tick) begin
          if (count_r != `TPW_ZERO_COUNT) begin
            count_nxt = count_r - `TPW_ONE_COUNT;
          end else if (ctrl1_r.one_shot_select) begin
            state_nxt = TPW_DONE;
          end else if (ctrl1_r.reload_select) begin
            count_nxt = reload_r;
          end else begin
            count_nxt = `TPW_FULL_RELOAD;
          end
        end
      end
      // One shot finished: hold at zero until reloaded or non-stop
      TPW_DONE: begin
        if (!ctrl1_r.one_shot_select) begin
          state_nxt = TPW_RUN;
        end
      end
      default: begin
        state_nxt = TPW_IDLE;
      end
    endcase
    // A count write starts a fresh span and wins over counting
    if (wr_count) begin
      count_nxt = {shared_high_bits[`TPW_SHB_RL_HI:`TPW_SHB_RL_LO], req.wdata};
      if (state_r == TPW_DONE) begin
        state_nxt = TPW_RUN;
      end
    end
  end

  // Counter register
  always_ff @(posedge clock) begin
    if (reset) begin
      count_r <= `TPW_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= TPW_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Underflow pulse, one cycle per event
  always_ff @(posedge clock) begin
    if (reset) begin
      uf_r <= 1'b0;
    end else begin
      uf_r <= underflow;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  // Sticky status: a new event in the clearing read's cycle survives
  always_ff @(posedge clock) begin
    if (reset) begin
      status_r <= `TPW_STATUS_RST;
    end else begin
      if (rd_status) begin
        status_r <= `TPW_STATUS_RST;
      end
      if (underflow) begin
        status_r[`TPW_ST_UNDERFLOW] <= 1'b1;
      end
    end
  end

  // Level interrupt while any unmasked status bit stands
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // PWM
  // ----------------------------------------------------------------
  // Period follows the reload span; active while the timer is enabled and count is below duty
  assign duty_full = {shared_high_bits[`TPW_SHB_DUTY_HI:`TPW_SHB_DUTY_LO], duty_low_r};
  assign pwm_active = ctrl1_r.timer_enable && (count_r < duty_full);
  assign pwm_level = pwm_active ^ ctrl1_r.pwm_polarity;

  // Pin mux: PWM when enabled, else the GPIO path unchanged
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (ctrl1_r.pwm_pin_enable) begin
      pin_out_r <= pwm_level;
      pin_oe_r <= 1'b1;
    end else begin
      pin_out_r <= gpio_out;
      pin_oe_r <= gpio_oe;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata_r <= `TPW_READ_ZERO;
    end else if (req.rd) begin
      case (req.addr)
        `TPW_OFF_COUNT: begin
          reg_rdata_r <= count_r[7:0];
        end
        `TPW_OFF_CTRL1: begin
          reg_rdata_r <= ctrl1_r;
        end
        `TPW_OFF_CTRL2: begin
          reg_rdata_r <= ctrl2_r;
        end
        `TPW_OFF_STATUS: begin
          reg_rdata_r <= status_r;
        end
        `TPW_OFF_MASK: begin
          reg_rdata_r <= mask_r;
        end
        // Duty and unmapped offsets read as zero
        default: begin
          reg_rdata_r <= `TPW_READ_ZERO;
        end
      endcase
    end else begin
      reg_rdata_r <= `TPW_READ_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = reg_rdata_r;
  assign irq = irq_r;
  assign underflow_event = uf_r;
  assign pwm_output_pin_out = pin_out_r;
  assign pwm_output_pin_oe = pin_oe_r;

endmodule : tpw_timer

//--- tpw_timer_assertions.sv
// Concurrent checks on the timer block ports
`timescale 1ns/100ps
module tpw_timer_chk (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire logic pwm_output_pin_out,
  input wire logic pwm_output_pin_oe,
  input wire logic underflow_event,
  input wire logic irq
);
  // ----------------------------------------
  // Mirrors of control one and the low byte of the last count write
  // ----------------------------------------
  logic [7:0] ctl_r; // Readable bits only
  // Tracks writes so checks know the mode without looking inside
  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_r <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h0A) begin
      ctl_r <= reg_wdata & 8'hC7;
    end
  end
  logic [7:0] rl_lo_r; // Low reload byte of the last count write
  // A zero reload may underflow on every tick, so the pulse check skips it
  always_ff @(posedge clock) begin
    if (reset) begin
      rl_lo_r <= 8'h00;
    end else if (reg_wr && reg_addr == 8'h09) begin
      rl_lo_r <= reg_wdata;
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  chk_ctrl_read: assert property (reg_rd && reg_addr == 8'h0A |=> reg_rdata == $past(ctl_r))
    else $error("control one read back wrong");
  chk_duty_hidden: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata == 8'h00)
    else $error("duty register readable");
  chk_event_single: assert property (underflow_event && rl_lo_r != 8'h00
    && !$past(reg_wr) |=> !underflow_event)
    else $error("underflow pulse longer than one cycle");
  chk_disabled_quiet: assert property (!ctl_r[0] |=> !underflow_event)
    else $error("underflow while disabled");
  chk_gpio_path: assert property (!ctl_r[7] |=> pwm_output_pin_out == $past(gpio_out)
    && pwm_output_pin_oe == $past(gpio_oe))
    else $error("pin not following general I/O");
  chk_pin_drive: assert property (ctl_r[7] |=> pwm_output_pin_oe)
    else $error("pin not driven by waveform");
  chk_idle_level: assert property (ctl_r[7] && !ctl_r[0] |=> pwm_output_pin_out == $past(ctl_r[6]))
    else $error("stopped waveform not at inactive level");
  chk_irq_cause: assert property ($rose(irq) |-> $past(underflow_event) || $past(reg_wr, 2))
    else $error("interrupt without cause");
endmodule : tpw_timer_chk

bind tpw_timer tpw_timer_chk tpw_timer_chk_i (
  .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe), .pwm_output_pin_out(pwm_output_pin_out),
  .pwm_output_pin_oe(pwm_output_pin_oe), .underflow_event(underflow_event), .irq(irq)
);

//--- tpw_timer_tb.sv
// Self-checking testbench for the timer block
`timescale 1ns/100ps
module tpw_timer_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] shb = 8'h00; // Shared high bits from outside
  logic ext_pin = 1'b0;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_out;
  logic pin_oe;
  logic uf;
  logic irq;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  tpw_timer tpw_timer_i (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shared_high_bits(shb),
    .external_count_clock_pin(ext_pin), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pwm_output_pin_out(pin_out), .pwm_output_pin_oe(pin_oe),
    .underflow_event(uf), .irq(irq)
  );
  // Clock at 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Strobe is raised at one edge and dropped at the taking edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    check("read data", reg_rdata, exp);
  endtask : rd
  // Waits for one underflow pulse, bounded so a dead timer cannot hang
  task automatic wait_uf(output int cyc);
    cyc = 0;
    do begin
      @(posedge clock);
      #1;
      cyc++;
    end while (uf !== 1'b1 && cyc < 3000);
    check("underflow seen", uf, 1'b1);
  endtask : wait_uf
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(8'h0A, 8'h00);
    rd(8'h0B, 8'h3F);
    rd(8'h30, 8'h00); // Unmapped
    wr(8'h0A, 8'hFE);
    rd(8'h0A, 8'hC6);
    wr(8'h0B, 8'hF0);
    rd(8'h0B, 8'h30);
    // Count load while stopped, upper bits from the shared register
    shb <= 8'h80;
    wr(8'h09, 8'hAB);
    rd(8'h09, 8'hAB);
    // Free run from the instruction clock, both reload kinds
    wr(8'h0B, 8'h08);
    for (int m = 0; m < 2; m++) begin
      shb <= 8'h40;
      wr(8'h09, 8'h05);
      wr(8'h0A, {6'h00, m[0], 1'b1});
      wait_uf(n);
      wr(8'h0A, 8'h00);
      repeat (10) @(posedge clock);
      rd(8'h09, m ? 8'h03 : 8'hFD);
    end
    rd(8'h20, 8'h01);
    // One-shot with the interrupt unmasked
    shb <= 8'h00;
    wr(8'h21, 8'h01);
    rd(8'h21, 8'h01);
    wr(8'h09, 8'h03);
    wr(8'h0A, 8'h07);
    wait_uf(n);
    repeat (20) @(posedge clock);
    #1;
    check("irq raised", irq, 1'b1);
    rd(8'h09, 8'h00);
    rd(8'h20, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    check("irq cleared", irq, 1'b0);
    // Prescaler rates, reload of one gives two ticks a period
    wr(8'h09, 8'h01);
    wr(8'h0A, 8'h03);
    wait_uf(n);
    wait_uf(n);
    check("bypass period", n[9:0], 10'h002);
    for (int s = 0; s < 8; s++) begin
      wr(8'h0B, {5'h01, 3'(s - 1)});
      wr(8'h0B, {5'h01, s[2:0]});
      wr(8'h0B, {5'h00, s[2:0]});
      wait_uf(n);
      wait_uf(n);
      check("prescaled period", n[9:0], 10'(4 << s));
    end
    // External pin: three rises and two falls while running
    for (int e = 0; e < 2; e++) begin
      wr(8'h0A, 8'h00);
      wr(8'h09, 8'h10);
      wr(8'h0B, {3'b001, e[0], 4'hF});
      wr(8'h0A, 8'h01);
      for (int i = 0; i < 5; i++) begin
        ext_pin <= ~i[0];
        repeat (6) @(posedge clock);
      end
      wr(8'h0A, 8'h00);
      ext_pin <= 1'b0;
      repeat (6) @(posedge clock);
      rd(8'h09, e ? 8'h0E : 8'h0D);
    end
    // Waveform level for both polarities and both duty extremes
    wr(8'h0B, 8'h08);
    wr(8'h09, 8'h80);
    for (int k = 0; k < 4; k++) begin
      shb <= {4'h0, {2{k[1]}}, 2'b00};
      wr(8'h0C, {8{k[1]}});
      wr(8'h0A, {1'b1, k[0], 6'h01});
      repeat (4) @(posedge clock);
      #1;
      check("pin enable", pin_oe, 1'b1);
      check("pin level", pin_out, k[1] ^ k[0]);
    end
    rd(8'h0C, 8'h00);
    // General I/O owns the pin when the waveform is off
    wr(8'h0A, 8'h00);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check("gpio level", {pin_out, pin_oe}, 2'b11);
    finish_test();
  end
endmodule : tpw_timer_tb
